// ==== logic/dbv_regs.sv ====
// Register bank for two step-down outputs: voltage codes, go bits, slew, mode, soft off.
// Assumes the serial slave pulses the write strobe in the cycle its last data bit completes,
// and that pins and the switching-cycle tick arrive asynchronously.
`timescale 1ns/1ns

// Function
// - Seven-bit code, 10 mV steps from 0.68 V
// - Go bit hands voltage to register code
// - Slew field doubles cycles per step
// - Mode field: pin, fixed, skip, reserved
// - Command bit 0 switches output off
// - Second output has own registers, same layout
// - Paralleled mode uses first output registers only
// - Write takes effect on last data bit
module dbv_regs
  import dbv_pkg::*;
#(
  parameter int STEP_CNT_W = 7
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Byte access from the serial slave
  input  wire dbv_wr_type       wr,
  input  wire logic [7:0]       rd_addr,
  output logic [7:0]            rd_data,
  // Asynchronous pins from the analog side
  input  wire logic             mode_pin_skip,
  input  wire logic             share_pin,
  input  wire logic             switch_tick,
  // Settings to the two regulator loops
  output dbv_out_type [1:0]     buck_out
);

  // Elaboration guard: slew 111 needs a count of 128 switching cycles
  if (STEP_CNT_W < 7) begin : g_width_check
    $error("STEP_CNT_W must hold 128 cycles");
  end

  // Mode resolution, shared by both outputs
  function automatic logic skip_of(input dbv_mode_type m, input logic pin);
    case (m)
      MODE_BY_PIN:     skip_of = pin;
      MODE_AUTO_SKIP:  skip_of = 1'b1;
      default:         skip_of = 1'b0; // Reserved held at fixed frequency, the safe choice
    endcase
  endfunction

  // Command register as read back; reserved bits 7 and 3 forced to zero
  function automatic logic [7:0] cmd_byte(input dbv_cmd_type c);
    cmd_byte                  = 8'h00;
    cmd_byte[SLEW_HI:SLEW_LO] = c.slew;
    cmd_byte[MODE_HI:MODE_LO] = c.mode;
    cmd_byte[OFF_BIT]         = c.soft_off;
  endfunction

  // Stored registers
  dbv_sel_type sel_reg   [2];
  dbv_sel_type sel_next  [2];
  dbv_cmd_type cmd_reg   [2];
  dbv_cmd_type cmd_next  [2];

  // Pin synchronisers, three stages so edge detection skips the first
  // A tick held under one clock high or low can be missed; ticks are slow
  logic [2:0]  mode_sync_reg;
  logic [2:0]  share_sync_reg;
  logic [2:0]  tick_sync_reg;
  logic        mode_s;
  logic        share_s;
  logic        tick_rise;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_sync_reg  <= 3'h0;
      share_sync_reg <= 3'h0;
      tick_sync_reg  <= 3'h0;
    end else begin
      mode_sync_reg  <= {mode_sync_reg[1:0], mode_pin_skip};
      share_sync_reg <= {share_sync_reg[1:0], share_pin};
      tick_sync_reg  <= {tick_sync_reg[1:0], switch_tick};
    end
  end

  // Only the second stage is read as a level; the third only marks the edge
  assign mode_s    = mode_sync_reg[1];
  assign share_s   = share_sync_reg[1];
  assign tick_rise = tick_sync_reg[1] & ~tick_sync_reg[2];

  // Write address decode
  logic hit_v1;
  logic hit_v2;
  logic hit_c1;
  logic hit_c2;
  dbv_cmd_type wr_cmd;

  assign hit_v1 = wr.strobe && (wr.addr == ADDR_OUT1_VOLTAGE);
  assign hit_v2 = wr.strobe && (wr.addr == ADDR_OUT2_VOLTAGE);
  assign hit_c1 = wr.strobe && (wr.addr == ADDR_OUT1_COMMAND);
  assign hit_c2 = wr.strobe && (wr.addr == ADDR_OUT2_COMMAND);
  // Reserved bits 7 and 3 dropped on write
  // A reserved mode code is kept as written; the loop runs it at fixed frequency
  assign wr_cmd = '{slew:     wr.data[SLEW_HI:SLEW_LO],
                    mode:     dbv_mode_type'(wr.data[MODE_HI:MODE_LO]),
                    soft_off: wr.data[OFF_BIT]};

  // Next register values
  assign sel_next[0] = hit_v1 ? dbv_sel_type'(wr.data) : sel_reg[0];
  assign sel_next[1] = hit_v2 ? dbv_sel_type'(wr.data) : sel_reg[1];
  assign cmd_next[0] = hit_c1 ? wr_cmd : cmd_reg[0];
  assign cmd_next[1] = hit_c2 ? wr_cmd : cmd_reg[1];

  // Storage; the strobe cycle is the completing data bit, so the edge ending it commits
  // Idle bus fields are ignored, so stale address bytes cannot load
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_reg[0] <= dbv_sel_type'(VOLTAGE_RESET);
      sel_reg[1] <= dbv_sel_type'(VOLTAGE_RESET);
      cmd_reg[0] <= dbv_cmd_type'(COMMAND_RESET[5:0]);
      cmd_reg[1] <= dbv_cmd_type'(COMMAND_RESET[5:0]);
    end else begin
      sel_reg[0] <= sel_next[0];
      sel_reg[1] <= sel_next[1];
      cmd_reg[0] <= cmd_next[0];
      cmd_reg[1] <= cmd_next[1];
    end
  end

  // Read decode, registered; unmapped and status offsets return zero
  // Status offset is not built here, so the host sees zero there
  logic [7:0] rd_next;
  logic [7:0] rd_cmd1;
  logic [7:0] rd_cmd2;

  assign rd_cmd1 = cmd_byte(cmd_reg[0]);
  assign rd_cmd2 = cmd_byte(cmd_reg[1]);

  always_comb begin
    if (rd_addr == ADDR_OUT1_VOLTAGE) begin
      rd_next = sel_reg[0];
    end else if (rd_addr == ADDR_OUT2_VOLTAGE) begin
      rd_next = sel_reg[1];
    end else if (rd_addr == ADDR_OUT1_COMMAND) begin
      rd_next = rd_cmd1;
    end else if (rd_addr == ADDR_OUT2_COMMAND) begin
      rd_next = rd_cmd2;
    end else begin
      rd_next = READ_UNMAPPED;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= READ_UNMAPPED;
    end else begin
      rd_data <= rd_next;
    end
  end

  // Per-output ramp and settings
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_out
      // Paralleled operation slaves output 2 to output 1 settings
      // Output 2 registers still store and read back while shared
      dbv_sel_type           eff_sel;
      dbv_cmd_type           eff_cmd;
      logic [6:0]            code_reg;
      logic [6:0]            code_next;
      logic [STEP_CNT_W-1:0] cnt_reg;
      logic [STEP_CNT_W-1:0] cnt_next;
      logic [STEP_CNT_W-1:0] last_cnt;
      logic                  step;
      dbv_out_type           out_next;

      assign eff_sel = (share_s && i == 1) ? sel_reg[0] : sel_reg[i];
      assign eff_cmd = (share_s && i == 1) ? cmd_reg[0] : cmd_reg[i];

      // Step every 2^slew switching cycles
      // Counter restarts after each step; a slew change counts on from the current value, but a value past the new last count goes to zero with no step
      assign last_cnt = STEP_CNT_W'((1 << eff_cmd.slew) - 1);
      assign step     = tick_rise && (cnt_reg == last_cnt);
      assign cnt_next = !tick_rise ? cnt_reg :
                        (cnt_reg >= last_cnt) ? '0 : cnt_reg + 1'b1;

      // Without go the code follows the register at once, no ramp owed
      // The ramp never overshoots: it stops on the target code
      always_comb begin
        code_next = code_reg;
        if (!eff_sel.go) begin
          code_next = eff_sel.code;
        end else if (step && code_reg < eff_sel.code) begin
          code_next = code_reg + 7'h01;
        end else if (step && code_reg > eff_sel.code) begin
          code_next = code_reg - 7'h01;
        end
      end

      // All loop settings leave through one flop so the loop sees them together
      assign out_next = '{reg_control: eff_sel.go,
                          code:        code_next,
                          millivolts:  BASE_MV + 11'({4'h0, code_next} * STEP_MV),
                          pulse_skip:  skip_of(eff_cmd.mode, mode_s),
                          enabled:     ~eff_cmd.soft_off};

      // Outputs wake enabled and divider-controlled, matching the register defaults
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          code_reg    <= 7'h00;
          cnt_reg     <= '0;
          buck_out[i] <= '{reg_control: 1'b0, code: 7'h00, millivolts: BASE_MV,
                           pulse_skip: 1'b0, enabled: 1'b1};
        end else begin
          code_reg    <= code_next;
          cnt_reg     <= cnt_next;
          buck_out[i] <= out_next;
        end
      end
    end
  endgenerate

endmodule

// ==== logic/dbv_pkg.sv ====
// Shared constants and carrier types for the dual buck voltage command registers.
// Assumes one 10 MHz clock domain and an upstream serial slave that delivers byte writes.
package dbv_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_OUT1_VOLTAGE = 8'h00;
  localparam logic [7:0] ADDR_OUT2_VOLTAGE = 8'h01;
  localparam logic [7:0] ADDR_OUT1_COMMAND = 8'h02;
  localparam logic [7:0] ADDR_OUT2_COMMAND = 8'h03;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // Reset values
  localparam logic [7:0] VOLTAGE_RESET     = 8'h00;
  localparam logic [7:0] COMMAND_RESET     = 8'h00;

  // Field positions
  localparam int GO_BIT     = 7;
  localparam int SLEW_HI    = 6;
  localparam int SLEW_LO    = 4;
  localparam int MODE_HI    = 2;
  localparam int MODE_LO    = 1;
  localparam int OFF_BIT    = 0;

  // Voltage code scale in millivolts
  localparam logic [10:0] BASE_MV = 11'h2a8; // 680 mV at code 0
  localparam logic [10:0] STEP_MV = 11'h00a; // 10 mV per code step

  // Light-load mode encodings
  typedef enum logic [1:0] {
    MODE_BY_PIN     = 2'b00,
    MODE_FIXED_FREQ = 2'b01,
    MODE_AUTO_SKIP  = 2'b10,
    MODE_RESERVED   = 2'b11
  } dbv_mode_type;

  // Voltage-selection register content
  typedef struct packed {
    logic       go;
    logic [6:0] code;
  } dbv_sel_type;

  // Command register content, reserved bits dropped
  typedef struct packed {
    logic [2:0]   slew;
    dbv_mode_type mode;
    logic         soft_off;
  } dbv_cmd_type;

  // Byte write from the serial front end
  typedef struct packed {
    logic       strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } dbv_wr_type;

  // Settings handed to one regulator loop
  typedef struct packed {
    logic        reg_control;
    logic [6:0]  code;
    logic [10:0] millivolts;
    logic        pulse_skip;
    logic        enabled;
  } dbv_out_type;
endpackage

// ==== verif/dbv_regs_properties.sv ====
// Concurrent checks on the register bank ports.
// Assumes one clock domain and the bank's synchronous active-low reset.
`timescale 1ns/1ns
module dbv_regs_properties
  import dbv_pkg::*;
#(
  parameter int STEP_CNT_W = 7
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  // Byte access
  input wire dbv_wr_type        wr,
  input wire logic [7:0]        rd_addr,
  input wire logic [7:0]        rd_data,
  // Pins
  input wire logic              mode_pin_skip,
  input wire logic              share_pin,
  input wire logic              switch_tick,
  // Loop settings
  input wire dbv_out_type [1:0] buck_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Writes landing on the first output
  sequence s_sel1_write;
    wr.strobe && wr.addr == ADDR_OUT1_VOLTAGE;
  endsequence
  sequence s_cmd1_write;
    wr.strobe && wr.addr == ADDR_OUT1_COMMAND;
  endsequence
  a_millivolt_scale: assert property (
    buck_out[0].millivolts == BASE_MV + STEP_MV * buck_out[0].code) else $error("bad scale");
  a_go_hands_over: assert property (
    s_sel1_write |-> ##2 buck_out[0].reg_control == $past(wr.data[GO_BIT], 2))
    else $error("go bit not applied");
  a_soft_off_bit: assert property (
    s_cmd1_write |-> ##2 buck_out[0].enabled == !$past(wr.data[OFF_BIT], 2))
    else $error("soft off not applied");
  a_mode_skip: assert property (
    s_cmd1_write ##0 wr.data[MODE_HI:MODE_LO] == 2'b10 |-> ##2 buck_out[0].pulse_skip)
    else $error("skip mode not applied");
  a_cmd_reserved_zero: assert property (
    rd_addr == ADDR_OUT1_COMMAND || rd_addr == ADDR_OUT2_COMMAND |=> !rd_data[7] && !rd_data[3])
    else $error("reserved bit read as one");
  a_unmapped_zero: assert property (
    rd_addr > ADDR_OUT2_COMMAND |=> rd_data == READ_UNMAPPED) else $error("unmapped not zero");
  a_ramp_one_step: assert property (
    buck_out[0].reg_control && $past(buck_out[0].reg_control)
    |-> (buck_out[0].code - $past(buck_out[0].code)) inside {7'h00, 7'h01, 7'h7f})
    else $error("ramp jumped");
  a_share_follows: assert property (
    share_pin [*5] |-> buck_out[1].enabled == buck_out[0].enabled
    && buck_out[1].reg_control == buck_out[0].reg_control
    && buck_out[1].pulse_skip == buck_out[0].pulse_skip)
    else $error("shared output diverged");
endmodule

// ==== verif/dbv_host.sv ====
// Host model: byte writes and registered reads into the bank.
// Assumes the caller stays in one process; one idle cycle follows each write.
`timescale 1ns/1ns
module dbv_host
  import dbv_pkg::*;
(
  // Clock and read return
  input wire logic  clock,
  input wire logic [7:0] rd_data,
  // Requests
  output dbv_wr_type wr,
  output logic [7:0] rd_addr
);
  initial begin
    wr = '0;
    rd_addr = 8'h00;
  end
  // Released fields flip so stale bytes never look valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) wr <= '{1'b1, a, d};
    @(posedge clock) wr <= '{1'b0, ~a, ~d};
  endtask
  // Data lands one edge after the address is taken
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) rd_addr <= a;
    repeat (2) @(posedge clock);
    d = rd_data;
  endtask
endmodule

// ==== verif/dual_buck_vid_command_regs_test.sv ====
// Self-checking bench for the dual buck register bank.
// Assumes the host model issues bus traffic; pins and tick are driven here.
`timescale 1ns/1ns
module dual_buck_vid_command_regs_test
  import dbv_pkg::*;
;
  logic              clock, rst_n, mode_pin_skip, share_pin, switch_tick;
  dbv_wr_type        wr;
  logic [7:0]        rd_addr, rd_data, got, a, d;
  dbv_out_type [1:0] buck_out;
  int                n_mismatch = 0, n_compared = 0;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  dbv_host dbv_host_i (.clock(clock), .rd_data(rd_data), .wr(wr), .rd_addr(rd_addr));
  dbv_regs #(.STEP_CNT_W(7)) dbv_regs_i (.clock(clock), .rst_n(rst_n), .wr(wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .mode_pin_skip(mode_pin_skip),
    .share_pin(share_pin), .switch_tick(switch_tick), .buck_out(buck_out));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Command bytes lose bits 7 and 3
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
    return a[1] ? (d & 8'h77) : d;
  endfunction
  // Loop voltage in millivolts for a code: base plus one step per code
  function automatic logic [10:0] exp_mv(input logic [6:0] c);
    return BASE_MV + STEP_MV * {4'h0, c};
  endfunction
  // Four edges cover pin synchronisers plus the output flop
  task automatic settle();
    repeat (4) @(posedge clock);
    #10;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock) switch_tick <= 1'b1;
      repeat (3) @(posedge clock);
      switch_tick <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    mode_pin_skip = 1'b1;
    share_pin = 1'b0;
    switch_tick = 1'b0;
    void'($urandom(32'h3b1c));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      dbv_host_i.read(8'(i), got);
      check(got, 8'h00);
    end
    #10;
    check(buck_out[0].millivolts, BASE_MV);
    check(buck_out[0].enabled, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? 8'(i) : 8'($urandom_range(3));
      d = (i < 4) ? 8'hff : 8'($urandom);
      dbv_host_i.write(a, d);
      dbv_host_i.read(a, got);
      check(got, exp_rd(a, d));
    end
    // Unmapped offset drops the byte and still reads zero
    dbv_host_i.write(8'h04, 8'hff);
    dbv_host_i.read(8'h04, got);
    check(got, 8'h00);
    $display("test readback done");
    // Pin asks for skipping, so mode 00 defers to it
    for (int m = 0; m < 4; m++) begin
      dbv_host_i.write(ADDR_OUT1_COMMAND, {5'h00, 2'(m), m[0]});
      settle();
      check(buck_out[0].pulse_skip, m == 2 || m == 0);
      check(buck_out[0].enabled, !m[0]);
    end
    // Pin now asks for fixed frequency, so mode 00 follows it there
    @(posedge clock) mode_pin_skip <= 1'b0;
    dbv_host_i.write(ADDR_OUT1_COMMAND, 8'h00);
    settle();
    check(buck_out[0].pulse_skip, 1'b0);
    check(buck_out[0].enabled, 1'b1);
    $display("test mode done");
    // Loop outputs show the byte one edge after the write lands
    dbv_host_i.write(ADDR_OUT1_VOLTAGE, 8'h05);
    @(posedge clock);
    #10;
    check(buck_out[0].code, 7'h05);
    check(buck_out[0].millivolts, 11'h2da);
    check(buck_out[0].reg_control, 1'b0);
    dbv_host_i.write(ADDR_OUT1_COMMAND, 8'h10);
    dbv_host_i.write(ADDR_OUT1_VOLTAGE, 8'h87);
    settle();
    check(buck_out[0].code, 7'h05);
    ticks(2);
    settle();
    check(buck_out[0].code, 7'h06);
    ticks(4);
    settle();
    check(buck_out[0].code, 7'h07);
    check(buck_out[0].reg_control, 1'b1);
    // Slew 000 steps on every tick, slew 111 only on the 128th
    dbv_host_i.write(ADDR_OUT1_COMMAND, 8'h00);
    dbv_host_i.write(ADDR_OUT1_VOLTAGE, 8'h8a);
    ticks(3);
    settle();
    check(buck_out[0].code, 7'h0a);
    dbv_host_i.write(ADDR_OUT1_COMMAND, 8'h70);
    dbv_host_i.write(ADDR_OUT1_VOLTAGE, 8'h8b);
    ticks(127);
    settle();
    check(buck_out[0].code, 7'h0a);
    ticks(1);
    settle();
    check(buck_out[0].code, 7'h0b);
    $display("test ramp done");
    dbv_host_i.write(ADDR_OUT2_VOLTAGE, 8'h20);
    settle();
    check(buck_out[1].code, 7'h20);
    check(buck_out[1].millivolts, exp_mv(7'h20));
    @(posedge clock) share_pin <= 1'b1;
    dbv_host_i.write(ADDR_OUT2_COMMAND, 8'h01);
    settle();
    check(buck_out[1].enabled, 1'b1);
    check(buck_out[1].reg_control, 1'b1);
    @(posedge clock) share_pin <= 1'b0;
    settle();
    check(buck_out[1].enabled, 1'b0);
    check(buck_out[1].reg_control, 1'b0);
    $display("test share done");
    // Second reset in mid-run brings every register back to its default
    @(posedge clock) rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    dbv_host_i.read(ADDR_OUT2_COMMAND, got);
    check(got, 8'h00);
    #10;
    check(buck_out[1].code, 7'h00);
    check(buck_out[1].enabled, 1'b1);
    check(buck_out[0].reg_control, 1'b0);
    $display("test second reset done");
    end_of_test();
  end
endmodule
bind dbv_regs dbv_regs_properties #(.STEP_CNT_W(STEP_CNT_W)) dbv_regs_properties_i (
  .clock(clock), .rst_n(rst_n), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
  .mode_pin_skip(mode_pin_skip), .share_pin(share_pin), .switch_tick(switch_tick),
  .buck_out(buck_out));
